// *** design/rtoc_pkg.sv ***
// Constants, register map and carrier types for the real-time output cutoff block.
// Assumes a 32-bit AXI4-Lite register bus with one 8-bit register per aligned word.
package rtoc_pkg;

  localparam int          RTOC_CHANNELS   = 8;
  localparam int          RTOC_REG_W      = 8;
  localparam logic [7:0]  RTOC_REG_RESET  = 8'h00;

  // Byte addresses of the registers.
  localparam logic [7:0]  RTOC_ADDR_SRC   = 8'h00;
  localparam logic [7:0]  RTOC_ADDR_OUTL  = 8'h04;
  localparam logic [7:0]  RTOC_ADDR_OUTH  = 8'h08;
  localparam logic [7:0]  RTOC_ADDR_CENA  = 8'h0C;
  localparam logic [7:0]  RTOC_ADDR_CSEL  = 8'h10;
  localparam logic [7:0]  RTOC_ADDR_STAT  = 8'h14;
  localparam logic [7:0]  RTOC_ADDR_CFG   = 8'h18;

  // Output control fields: enables in the low nibble, inverts in the high nibble.
  localparam int          RTOC_EN_LSB     = 0;
  localparam int          RTOC_INV_LSB    = 4;
  localparam int          RTOC_HALF       = 4;

  // Status and configuration bits.
  localparam int          RTOC_STAT_CLR   = 0;
  localparam int          RTOC_STAT_FLAG  = 1;
  localparam int          RTOC_CFG_PEN    = 0;
  localparam int          RTOC_CFG_RISE   = 1;
  localparam int          RTOC_CFG_FALL   = 2;

  // Cutoff state select encodings.
  localparam logic [1:0]  RTOC_CUT_HIZ    = 2'b00;
  localparam logic [1:0]  RTOC_CUT_LOW    = 2'b01;
  localparam logic [1:0]  RTOC_CUT_HIGH   = 2'b10;
  localparam logic [1:0]  RTOC_CUT_IGNORE = 2'b11;

  localparam logic [1:0]  RTOC_RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RTOC_RESP_SLVERR = 2'b10;
  localparam int          RTOC_ADDR_W     = 8;

  // Low bit of the cutoff state select field that governs a channel.
  function automatic int rtoc_csel_lsb(input int ch);
    if (ch == 7) begin
      return 6;
    end else if (ch == 6) begin
      return 2;
    end else if (ch >= 3) begin
      return 4;
    end
    return 0;
  endfunction : rtoc_csel_lsb

  typedef struct packed {
    logic [7:0] timer_source_select;
    logic [7:0] output_control_low;
    logic [7:0] output_control_high;
    logic [7:0] cutoff_enable_reg;
    logic [7:0] cutoff_state_select;
    logic [7:0] config_reg;
  } rtoc_regs_s;

  typedef struct packed {
    logic       aw_held;
    logic [7:0] aw_addr;
    logic       w_held;
    logic [7:0] w_data;
    logic       w_strb0;
    logic       awready;
    logic       wready;
    logic       bvalid;
    logic [1:0] bresp;
    logic       arready;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rtoc_axi_s;

  typedef struct packed {
    rtoc_regs_s regs;
    logic       cutoff_flag;
    logic       trig_prev;
    logic [7:0] pin_level;
    logic [7:0] pin_oe;
    rtoc_axi_s  axi;
  } rtoc_state_s;

endpackage : rtoc_pkg

// *** design/rtoc_top.sv ***
// Eight-channel real-time output controller with external forced cutoff, AXI4-Lite registers.
// Assumes timer waves and the cutoff trigger are synchronous to aclk; the port pad resolves
// channel_output_pin level with its output enable.
//
// Overview of operation
// - Each channel picks timer channel 1 or 3.
// - Source select 0 routes timer channel 1.
// - Enable and invert give wave, inverse, low, high.
// - Normal output unless enabled, flagged, not ignored.
// - Cutoff select 00 Hi-Z, 01 low, 10 high.
// - Trigger edge cuts off cutoff-enabled channels.
// - Trigger edge rising, falling or both, configurable.
// - Cutoff reaches pins within two clocks.
// - Normal outputs return two clocks after clear.
// - Writing clear bit with flag set clears flag.
// - Output control writable live; enable, invert together.
// - Peripheral enable 0 holds controller initialized.
// - Flag reads 1 after cutoff, 0 otherwise.
// - Clear bit reads 0; other status read-only.
// - Cutoff select fields map to channel groups.
// - Registers are 8 bits, reset to 00H.
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
module rtoc_top
  import rtoc_pkg::*;
#(
  parameter int NCH = RTOC_CHANNELS
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             clk_en,
  input  wire logic             timer_ch1_wave,
  input  wire logic             timer_ch3_wave,
  input  wire logic             cutoff_trigger_input,
  output logic [NCH-1:0]        channel_output_pin,
  output logic [NCH-1:0]        channel_output_oe,
  output logic                  cutoff_flag,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic [2:0]       s_axi_awprot,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic [2:0]       s_axi_arprot,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);

  rtoc_state_s state_reg;
  rtoc_state_s state_next;

  logic [NCH-1:0] chan_level;
  logic [NCH-1:0] chan_oe;
  logic [15:0]    ctl_all;

  assign ctl_all = {state_reg.regs.output_control_high, state_reg.regs.output_control_low};

  // Pin levels are computed from registered state and the live timer waves, so the pin flops add one stage
  // after the flag; that fixes both entry and exit latencies at two clocks.
  for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
    localparam int NIB  = (ch / RTOC_HALF) * RTOC_REG_W;
    localparam int POS  = ch % RTOC_HALF;
    localparam int CLSB = rtoc_csel_lsb(ch);
    logic       wave;
    logic       out_en;
    logic       out_inv;
    logic       normal;
    logic [1:0] csel;
    logic       cut_on;

    assign wave    = state_reg.regs.timer_source_select[ch] ?
                     timer_ch3_wave : timer_ch1_wave;
    assign out_en  = ctl_all[NIB + RTOC_EN_LSB + POS];
    assign out_inv = ctl_all[NIB + RTOC_INV_LSB + POS];
    assign normal  = out_en ? (wave ^ out_inv) : out_inv;
    assign csel    = state_reg.regs.cutoff_state_select[CLSB +: 2];
    assign cut_on  = state_reg.regs.cutoff_enable_reg[ch] && state_reg.cutoff_flag &&
                     (csel != RTOC_CUT_IGNORE);

    always_comb begin
      chan_level[ch] = normal;
      chan_oe[ch]    = 1'b1;
      if (cut_on) begin
        chan_level[ch] = (csel == RTOC_CUT_HIGH);
        chan_oe[ch]    = (csel != RTOC_CUT_HIZ);
      end
    end
  end

  function automatic logic [7:0] rtoc_read(input rtoc_state_s s, input logic [7:0] addr);
    logic [7:0] v;
    v = RTOC_REG_RESET;
    case (addr)
      RTOC_ADDR_SRC:  v = s.regs.timer_source_select;
      RTOC_ADDR_OUTL: v = s.regs.output_control_low;
      RTOC_ADDR_OUTH: v = s.regs.output_control_high;
      RTOC_ADDR_CENA: v = s.regs.cutoff_enable_reg;
      RTOC_ADDR_CSEL: v = s.regs.cutoff_state_select;
      RTOC_ADDR_STAT: v[RTOC_STAT_FLAG] = s.cutoff_flag;
      RTOC_ADDR_CFG:  v = s.regs.config_reg;
      default:        v = RTOC_REG_RESET;
    endcase
    return v;
  endfunction : rtoc_read

  function automatic logic rtoc_mapped(input logic [7:0] addr);
    return addr inside {RTOC_ADDR_SRC, RTOC_ADDR_OUTL, RTOC_ADDR_OUTH, RTOC_ADDR_CENA,
                        RTOC_ADDR_CSEL, RTOC_ADDR_STAT, RTOC_ADDR_CFG};
  endfunction : rtoc_mapped

  always_comb begin
    logic       pen;
    logic       trig_edge;
    logic       clear_req;
    logic       do_write;
    logic [7:0] wd;

    state_next = state_reg;
    pen        = state_reg.regs.config_reg[RTOC_CFG_PEN];
    clear_req  = 1'b0;
    do_write   = 1'b0;
    wd         = state_reg.axi.w_data;

    trig_edge = (state_reg.regs.config_reg[RTOC_CFG_RISE] &&
                 cutoff_trigger_input && !state_reg.trig_prev) ||
                (state_reg.regs.config_reg[RTOC_CFG_FALL] &&
                 !cutoff_trigger_input && state_reg.trig_prev);
    state_next.trig_prev = cutoff_trigger_input;

    // Write address and data are held independently, so either may arrive first.
    if (s_axi_awvalid && state_reg.axi.awready) begin
      state_next.axi.aw_held = 1'b1;
      state_next.axi.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && state_reg.axi.wready) begin
      state_next.axi.w_held  = 1'b1;
      state_next.axi.w_data  = s_axi_wdata[7:0];
      state_next.axi.w_strb0 = s_axi_wstrb[0];
    end
    if (state_reg.axi.bvalid && s_axi_bready) begin
      state_next.axi.bvalid = 1'b0;
    end
    if (state_reg.axi.aw_held && state_reg.axi.w_held && !state_reg.axi.bvalid) begin
      do_write               = state_reg.axi.w_strb0;
      state_next.axi.aw_held = 1'b0;
      state_next.axi.w_held  = 1'b0;
      state_next.axi.bvalid  = 1'b1;
      state_next.axi.bresp   = rtoc_mapped(state_reg.axi.aw_addr) ?
                               RTOC_RESP_OKAY : RTOC_RESP_SLVERR;
    end

    // Control registers stay live while running so commutation can be reprogrammed on the fly.
    if (do_write) begin
      case (state_reg.axi.aw_addr)
        RTOC_ADDR_SRC:  state_next.regs.timer_source_select = wd;
        RTOC_ADDR_OUTL: state_next.regs.output_control_low  = wd;
        RTOC_ADDR_OUTH: state_next.regs.output_control_high = wd;
        RTOC_ADDR_CENA: state_next.regs.cutoff_enable_reg   = wd;
        RTOC_ADDR_CSEL: state_next.regs.cutoff_state_select = wd;
        RTOC_ADDR_STAT: clear_req = wd[RTOC_STAT_CLR];
        RTOC_ADDR_CFG:  state_next.regs.config_reg = wd;
        default:        state_next.regs = state_next.regs;
      endcase
    end

    // A trigger edge in the same cycle as a clear keeps the flag set.
    if (clear_req && state_reg.cutoff_flag) begin
      state_next.cutoff_flag = 1'b0;
    end
    if (trig_edge) begin
      state_next.cutoff_flag = 1'b1;
    end

    state_next.pin_level = chan_level;
    state_next.pin_oe    = chan_oe;

    // Disabled: everything but the configuration register is held at reset, pins released.
    if (!pen) begin
      state_next.regs.timer_source_select = RTOC_REG_RESET;
      state_next.regs.output_control_low  = RTOC_REG_RESET;
      state_next.regs.output_control_high = RTOC_REG_RESET;
      state_next.regs.cutoff_enable_reg   = RTOC_REG_RESET;
      state_next.regs.cutoff_state_select = RTOC_REG_RESET;
      state_next.cutoff_flag              = 1'b0;
      state_next.pin_level                = '0;
      state_next.pin_oe                   = '0;
      if (do_write && state_reg.axi.aw_addr == RTOC_ADDR_CFG) begin
        state_next.regs.config_reg = wd;
      end
    end

    if (state_reg.axi.rvalid && s_axi_rready) begin
      state_next.axi.rvalid = 1'b0;
    end
    if (s_axi_arvalid && state_reg.axi.arready) begin
      state_next.axi.rvalid = 1'b1;
      state_next.axi.rdata  = {24'h00_0000, rtoc_read(state_reg, s_axi_araddr)};
      state_next.axi.rresp  = rtoc_mapped(s_axi_araddr) ? RTOC_RESP_OKAY : RTOC_RESP_SLVERR;
    end

    state_next.axi.awready = !state_next.axi.aw_held && !state_next.axi.bvalid;
    state_next.axi.wready  = !state_next.axi.w_held && !state_next.axi.bvalid;
    state_next.axi.arready = !state_next.axi.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign channel_output_pin = state_reg.pin_level;
  assign channel_output_oe  = state_reg.pin_oe;
  assign cutoff_flag        = state_reg.cutoff_flag;
  assign s_axi_awready      = state_reg.axi.awready;
  assign s_axi_wready       = state_reg.axi.wready;
  assign s_axi_bvalid       = state_reg.axi.bvalid;
  assign s_axi_bresp        = state_reg.axi.bresp;
  assign s_axi_arready      = state_reg.axi.arready;
  assign s_axi_rvalid       = state_reg.axi.rvalid;
  assign s_axi_rdata        = state_reg.axi.rdata;
  assign s_axi_rresp        = state_reg.axi.rresp;

endmodule : rtoc_top

// *** tb/rtoc_timer_model.sv ***
// Timer unit stand-in: two channel outputs settling at commanded levels.
// Assumes the bench changes the command only between its checks.
module rtoc_timer_model (
  input  wire logic       aclk,
  input  wire logic [1:0] level,
  output logic            timer_ch1_wave,
  output logic            timer_ch3_wave
);
  timeunit 1ns;
  timeprecision 1ns;
  // Registered like a real timer output, so a new level lands one edge late.
  always_ff @(posedge aclk) begin
    timer_ch1_wave <= level[0];
    timer_ch3_wave <= level[1];
  end
endmodule : rtoc_timer_model

// *** tb/rtoc_checker.sv ***
// Port checks for the cutoff controller, bound into rtoc_top.
// Assumes clk_en is held high, so every rising edge is an active one.
module rtoc_checker #(
  parameter int NCH = 8
) (
  input wire logic           aclk,
  input wire logic           aresetn,
  input wire logic           cutoff_trigger_input,
  input wire logic           cutoff_flag,
  input wire logic [NCH-1:0] channel_output_oe,
  input wire logic           s_axi_awready,
  input wire logic           s_axi_bvalid,
  input wire logic [1:0]     s_axi_bresp,
  input wire logic           s_axi_bready,
  input wire logic           s_axi_arvalid,
  input wire logic           s_axi_arready,
  input wire logic           s_axi_rvalid,
  input wire logic [31:0]    s_axi_rdata,
  input wire logic           s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_flag_cause: assert property ($rose(cutoff_flag) |->
    $past(cutoff_trigger_input) != $past(cutoff_trigger_input, 2)) else $error("flag set without trigger edge");
  a_flag_clear: assert property ($fell(cutoff_flag) |-> $rose(s_axi_bvalid))
    else $error("flag dropped without a write");
  a_reset_out: assert property ($rose(aresetn) |-> !cutoff_flag && channel_output_oe == '0)
    else $error("outputs active out of reset");
  a_b_stand: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_stand: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
    else $error("read data above bit 7");
  a_ar_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
endmodule : rtoc_checker

bind rtoc_top rtoc_checker #(.NCH(NCH)) rtoc_checker_inst (
  .aclk(aclk), .aresetn(aresetn), .cutoff_trigger_input(cutoff_trigger_input),
  .cutoff_flag(cutoff_flag), .channel_output_oe(channel_output_oe), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata), .s_axi_rready(s_axi_rready));

// *** tb/testbench.sv ***
// Self-checking bench: bus master, output table, cutoff and edge cases.
// Assumes the timer model drives both waves and clk_en stays high.
module testbench import rtoc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] src, outl, outh; logic [1:0] lvl; logic [7:0] pins;} rtoc_row_s;
  logic        aclk = 1'b0, aresetn, trig, awv, wv, bready, arv, rready;
  logic        awr, wrdy, bv, arr, rv, ch1, ch3, flag;
  logic [7:0]  awaddr, araddr, pins, oe;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, lvl;
  int          miscompares, n_checks, i, c, e;
  rtoc_row_s   rows[5] = '{'{8'h00, 8'h0F, 8'h0F, 2'h1, 8'hFF}, '{8'hF0, 8'h0F, 8'h0F, 2'h1, 8'h0F},
                           '{8'hF0, 8'hFF, 8'hFF, 2'h1, 8'hF0}, '{8'h00, 8'hF0, 8'h00, 2'h1, 8'h0F},
                           '{8'hAA, 8'h0F, 8'hF0, 2'h2, 8'hFA}};
  // Cutoff enable, state select, expected drive enables, expected driven levels.
  logic [31:0] cut[5] = '{32'h0F00_F0F0, 32'h0F55_FFF0, 32'h0FAA_FFFF, 32'h0FFF_FFFF, 32'hFF6D_FF78};
  always #20 aclk = ~aclk;
  rtoc_timer_model rtoc_timer_model_inst (.aclk(aclk), .level(lvl), .timer_ch1_wave(ch1), .timer_ch3_wave(ch3));
  rtoc_top rtoc_top_inst (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .timer_ch1_wave(ch1), .timer_ch3_wave(ch3),
    .cutoff_trigger_input(trig), .channel_output_pin(pins), .channel_output_oe(oe), .cutoff_flag(flag),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready));
  task automatic stop_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic hung();
    miscompares++;
    stop_test();
  endtask : hung
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int t;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    for (t = 0; t < 60; t++) begin
      @(posedge aclk);
      if (awr)
        awv <= 1'b0;
      if (wrdy)
        wv <= 1'b0;
      if (bv && bready)
        break;
      if (bv)
        bready <= 1'b1;
    end
    if (t == 60)
      hung();
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int t;
    araddr <= a;
    arv <= 1'b1;
    for (t = 0; t < 60; t++) begin
      @(posedge aclk);
      if (arr)
        arv <= 1'b0;
      if (rv && rready)
        break;
      if (rv)
        rready <= 1'b1;
    end
    if (t == 60)
      hung();
    rready <= 1'b0;
    chk(rdata, ed);
    chk(32'(rresp), 32'(er));
  endtask : rd
  initial begin
    aresetn = 1'b0; trig = 1'b0; awv = 1'b0; wv = 1'b0; bready = 1'b0; arv = 1'b0; rready = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; lvl = 2'h1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 7; i++)
      rd(8'(4 * i), 32'h0000_0000, RTOC_RESP_OKAY);
    wr(RTOC_ADDR_OUTL, 8'hFF, RTOC_RESP_OKAY);
    rd(RTOC_ADDR_OUTL, 32'h0000_0000, RTOC_RESP_OKAY);
    chk(32'(oe), 32'h0000_0000);
    wr(8'h1C, 8'h55, RTOC_RESP_SLVERR);
    rd(8'h1C, 32'h0000_0000, RTOC_RESP_SLVERR);
    wr(RTOC_ADDR_CFG, 8'h03, RTOC_RESP_OKAY);
    foreach (rows[i]) begin
      lvl <= rows[i].lvl;
      wr(RTOC_ADDR_SRC, rows[i].src, RTOC_RESP_OKAY);
      wr(RTOC_ADDR_OUTL, rows[i].outl, RTOC_RESP_OKAY);
      wr(RTOC_ADDR_OUTH, rows[i].outh, RTOC_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(32'(pins), 32'(rows[i].pins));
      chk(32'(oe), 32'h0000_00FF);
    end
    lvl <= 2'h1;
    // All channels back on timer channel 1, so every normal pin idles high for the cutoff table.
    wr(RTOC_ADDR_SRC, 8'h00, RTOC_RESP_OKAY);
    wr(RTOC_ADDR_OUTH, 8'h0F, RTOC_RESP_OKAY);
    for (c = 0; c < 5; c++) begin
      wr(RTOC_ADDR_CENA, 8'h00, RTOC_RESP_OKAY);
      wr(RTOC_ADDR_CSEL, cut[c][23:16], RTOC_RESP_OKAY);
      wr(RTOC_ADDR_CENA, cut[c][31:24], RTOC_RESP_OKAY);
      trig <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(32'(flag), 32'h0000_0001);
      chk(32'(oe), 32'(cut[c][15:8]));
      chk(32'(pins & oe), 32'(cut[c][7:0]));
      trig <= 1'b0;
      rd(RTOC_ADDR_STAT, 32'h0000_0002, RTOC_RESP_OKAY);
      wr(RTOC_ADDR_STAT, 8'h01, RTOC_RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(32'(flag), 32'h0000_0000);
      chk(32'({oe, pins}), 32'h0000_FFFF);
    end
    for (c = 1; c < 4; c++) begin
      wr(RTOC_ADDR_CFG, {5'h00, 2'(c), 1'b1}, RTOC_RESP_OKAY);
      for (e = 0; e < 2; e++) begin
        trig <= ~e[0];
        repeat (3) @(posedge aclk);
        chk(32'(flag), 32'(c[e]));
        if (flag)
          wr(RTOC_ADDR_STAT, 8'h01, RTOC_RESP_OKAY);
      end
    end
    wr(RTOC_ADDR_CFG, 8'h00, RTOC_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'(oe), 32'h0000_0000);
    rd(RTOC_ADDR_OUTL, 32'h0000_0000, RTOC_RESP_OKAY);
    stop_test();
  end
endmodule : testbench
